// ### flash_regs_params.svh
// Purpose: constants for the flash status and configuration registers
// Assumes: 8-bit registers, one clock domain
// Notes: bit positions, reset values, write masks and cycle counts only
`ifndef FLASH_REGS_PARAMS_SVH
`define FLASH_REGS_PARAMS_SVH
`define STS_BUSY_BIT 0
`define STS_WEL_BIT 1
`define STS_PROT_LSB 2
`define STS_PROT_MSB 5
`define CFG_DRV_LSB 0
`define CFG_DRV_MSB 2
`define CFG_BOTTOM_BIT 3
`define CFG_PRE_BIT 4
`define PROT_RESET 4'h0
`define BOTTOM_RESET 1'h0
`define PRE_RESET 1'h0
`define DRV_RESET 3'h7
`define STS_WMASK 8'h3C
`define CFG_WMASK 8'h1F
`define PROG_CYCLES 16'h0020
`define ERASE_CYCLES 16'h0080
`define WRITE_STATUS_CMD_CYCLES 16'h0010
`endif

// ### flash_regs_pkg.sv
// Purpose: types for the flash status and configuration registers
// Assumes: used with flash_regs_params.svh
// Notes: operation codes as seen by the register block
package flash_regs_pkg;
   typedef enum logic [2:0] {
      OP_NONE, OP_WRITE_ENABLE_CMD, OP_WRITE_STATUS_CMD, OP_PROG, OP_SECT, OP_BLOCK, OP_CHIP
   } op_e;
   typedef enum {ST_IDLE, ST_BUSY} state_e;
endpackage

// ### flash_status_config_regs.sv
// Purpose: status and configuration registers of a serial flash device
// Assumes: command decoder presents one-cycle decoded commands
// Notes: array size split into 2**AW units; protect level picks a span
`timescale 1ns/10ps
`include "flash_regs_params.svh"

// Functional notes
// (R01) busy flag high during program/erase/write
// (R02) write enable command sets latch
// (R03) program/erase dropped when latch clear
// (R04) latch clears when operation completes
// (R05) protected target: ignore, clear latch
// (R06) host polls busy before latch
// (R07) four protect bits, written by status write
// (R08) protect bits select blocked region
// (R09) chip erase only with all zero
// (R10) protect bits reset to zero
// (R11) bottom-select bit, zero means top
// (R12) bottom-select only via status write
// (R13) preamble enable drives dummy pattern
// (R14) preamble enable only via status write
// (R15) three-bit drive strength field
// (R16) new settings act once written
// (R17) reserved bits read zero
module flash_status_config_regs #(
   parameter int AW = 8
) (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   // decoded command, one-cycle pulse
   input wire logic CMD_VALID,
   input wire flash_regs_pkg::op_e CMD_OP,
   input wire logic [AW-1:0] CMD_ADDR,
   input wire logic [7:0] CMD_STATUS_DATA,
   input wire logic [7:0] CMD_CONFIG_DATA,
   // register read-back
   output logic [7:0] STATUS,
   output logic [7:0] CONFIG,
   // array operation launch
   output logic ARRAY_START,
   output flash_regs_pkg::op_e ARRAY_OP,
   // settings applied to the pads
   output logic PREAMBLE_ON,
   output logic [2:0] DRIVE_LEVEL,
   output logic PROTECT_BOTTOM
);
   logic [3:0] prot_q;
   logic bottom_q;
   logic pre_q;
   logic [2:0] drv_q;
   logic wel_q;
   logic busy_q;
   logic [15:0] cnt_q;
   flash_regs_pkg::state_e st_q;
   flash_regs_pkg::op_e op_q;
   logic is_array;
   logic blocked;
   logic accept;
   logic write_status_cmd_go;
   logic done;

   // true when address falls in span chosen by level and side
   function automatic logic in_protected(input logic [3:0] lvl,
                                         input logic bot,
                                         input logic [AW-1:0] a);
      logic [AW:0] span;
      logic [AW:0] lim;
      span = '0;
      lim = '0;
      if (lvl != 4'h0) begin
         if (int'(lvl) >= AW + 1) begin
            span = (AW+1)'(1) << AW;
         end else begin
            span = (AW+1)'(1) << (lvl - 4'h1);
         end
      end
      lim = ((AW+1)'(1) << AW) - span;
      if (bot) begin
         in_protected = {1'b0, a} < span;
      end else begin
         in_protected = {1'b0, a} >= lim && span != '0;
      end
   endfunction

   // classify the incoming command
   always_comb begin
      is_array = CMD_OP == flash_regs_pkg::OP_PROG ||
                 CMD_OP == flash_regs_pkg::OP_SECT ||
                 CMD_OP == flash_regs_pkg::OP_BLOCK ||
                 CMD_OP == flash_regs_pkg::OP_CHIP;
      // (R08) region blocking check
      // (R09) chip erase needs zero level
      if (CMD_OP == flash_regs_pkg::OP_CHIP) begin
         blocked = prot_q != 4'h0;
      end else begin
         blocked = in_protected(prot_q, bottom_q, CMD_ADDR);
      end
      // (R03) latch gates array work
      accept = CMD_VALID && is_array && wel_q && !blocked &&
               st_q == flash_regs_pkg::ST_IDLE;
      write_status_cmd_go = CMD_VALID && CMD_OP == flash_regs_pkg::OP_WRITE_STATUS_CMD &&
                wel_q && st_q == flash_regs_pkg::ST_IDLE;
      done = st_q == flash_regs_pkg::ST_BUSY && cnt_q == 16'h0000;
   end

   // operation sequencer; commands while busy are ignored
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         st_q <= flash_regs_pkg::ST_IDLE;
         cnt_q <= 16'h0000;
         op_q <= flash_regs_pkg::OP_NONE;
      end else begin
         unique case (st_q)
            flash_regs_pkg::ST_IDLE: begin
               if (accept || write_status_cmd_go) begin
                  st_q <= flash_regs_pkg::ST_BUSY;
                  op_q <= CMD_OP;
                  if (write_status_cmd_go) begin
                     cnt_q <= `WRITE_STATUS_CMD_CYCLES;
                  end else if (CMD_OP == flash_regs_pkg::OP_PROG) begin
                     cnt_q <= `PROG_CYCLES;
                  end else begin
                     cnt_q <= `ERASE_CYCLES;
                  end
               end
            end
            flash_regs_pkg::ST_BUSY: begin
               if (done) begin
                  st_q <= flash_regs_pkg::ST_IDLE;
                  op_q <= flash_regs_pkg::OP_NONE;
               end else begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
         endcase
      end
   end

   // (R01) busy flag tracks sequencer
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= (st_q == flash_regs_pkg::ST_BUSY && !done) ||
                   accept || write_status_cmd_go;
      end
   end

   // write enable latch
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         wel_q <= 1'b0;
      end else if (CMD_VALID && is_array && wel_q && blocked &&
                   st_q == flash_regs_pkg::ST_IDLE) begin
         // (R05) protected target clears latch
         wel_q <= 1'b0;
      end else if (done) begin
         // (R04) completion clears latch
         wel_q <= 1'b0;
      end else if (CMD_VALID && CMD_OP == flash_regs_pkg::OP_WRITE_ENABLE_CMD &&
                   st_q == flash_regs_pkg::ST_IDLE) begin
         // (R02) set by write enable
         wel_q <= 1'b1;
      end
   end

   // register contents commit on the edge that takes the status write
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         // (R10) unprotected after reset
         prot_q <= `PROT_RESET;
         bottom_q <= `BOTTOM_RESET;
         pre_q <= `PRE_RESET;
         drv_q <= `DRV_RESET;
      end else if (write_status_cmd_go) begin
         // (R07) protect level via status write
         prot_q <= CMD_STATUS_DATA[`STS_PROT_MSB:`STS_PROT_LSB];
         // (R11) bottom select stored
         // (R12) only status write alters it
         bottom_q <= CMD_CONFIG_DATA[`CFG_BOTTOM_BIT];
         // (R14) preamble via status write
         pre_q <= CMD_CONFIG_DATA[`CFG_PRE_BIT];
         // (R15) drive strength field
         drv_q <= CMD_CONFIG_DATA[`CFG_DRV_MSB:`CFG_DRV_LSB];
      end
   end

   // outputs all registered; reserved bits forced to zero
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         STATUS <= 8'h00;
         CONFIG <= 8'h00;
         ARRAY_START <= 1'b0;
         ARRAY_OP <= flash_regs_pkg::OP_NONE;
         PREAMBLE_ON <= `PRE_RESET;
         DRIVE_LEVEL <= `DRV_RESET;
         PROTECT_BOTTOM <= `BOTTOM_RESET;
      end else begin
         // (R17) reserved bits read zero
         STATUS <= {2'h0, prot_q, wel_q, busy_q} & (`STS_WMASK | 8'h03);
         CONFIG <= {3'h0, pre_q, bottom_q, drv_q} & `CFG_WMASK;
         ARRAY_START <= accept;
         ARRAY_OP <= accept ? CMD_OP : flash_regs_pkg::OP_NONE;
         // (R13) preamble pattern enable
         // (R16) settings act once written
         PREAMBLE_ON <= pre_q;
         DRIVE_LEVEL <= drv_q;
         PROTECT_BOTTOM <= bottom_q;
      end
   end

   // helper for checks: length of the current busy run; a counter is
   // used because a long repetition would make the tools crawl
   logic [15:0] busy_run_q;
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         busy_run_q <= 16'h0000;
      end else if (busy_q) begin
         busy_run_q <= busy_run_q + 16'h0001;
      end else begin
         busy_run_q <= 16'h0000;
      end
   end

   // checks: shared steps of the launch and busy handshake
   sequence s_launch;
      accept;
   endsequence
   sequence s_write_status_cmd_take;
      write_status_cmd_go;
   endsequence
   // busy shows one edge after the state flop, never at once
   sequence s_busy_seen;
      STATUS[0] == 1'b0 ##1 STATUS[0];
   endsequence
   sequence s_write_enable_cmd_take;
      CMD_VALID && CMD_OP == flash_regs_pkg::OP_WRITE_ENABLE_CMD &&
      st_q == flash_regs_pkg::ST_IDLE;
   endsequence

   // busy flag behaviour
   chk_busy_follows: assert property ( // (R01)
      @(posedge CLOCK) disable iff (RST) s_launch |=> s_busy_seen)
      else $error("busy not shown after launch");
   chk_write_status_cmd_busy: assert property ( // (R01)
      @(posedge CLOCK) disable iff (RST) s_write_status_cmd_take |=> s_busy_seen)
      else $error("busy not shown after status write");
   chk_busy_state: assert property ( // (R01)
      @(posedge CLOCK) disable iff (RST)
      busy_q == (st_q == flash_regs_pkg::ST_BUSY))
      else $error("busy flag disagrees with sequencer");
   // the longest cycle is an erase; anything longer is a stuck flag
   chk_busy_bound: assert property ( // (R01)
      @(posedge CLOCK) disable iff (RST)
      busy_run_q <= `ERASE_CYCLES + 16'h0001)
      else $error("busy flag stuck high");
   chk_busy_refuse: assert property ( // (R01)
      @(posedge CLOCK) disable iff (RST)
      CMD_VALID && st_q == flash_regs_pkg::ST_BUSY |=> !ARRAY_START)
      else $error("array op launched while busy");

   // write enable latch
   chk_wel_set: assert property ( // (R02)
      @(posedge CLOCK) disable iff (RST) s_write_enable_cmd_take |=> ##1 STATUS[1])
      else $error("latch not set by write enable");
   chk_no_wel_drop: assert property ( // (R03)
      @(posedge CLOCK) disable iff (RST)
      CMD_VALID && is_array && !wel_q |=> !ARRAY_START)
      else $error("array op without latch");
   chk_done_clear: assert property ( // (R04)
      @(posedge CLOCK) disable iff (RST) done |=> !wel_q)
      else $error("latch not cleared at completion");
   chk_done_status: assert property ( // (R04)
      @(posedge CLOCK) disable iff (RST)
      done |=> ##1 STATUS[1:0] == 2'h0)
      else $error("status not idle after completion");
   chk_prot_clear: assert property ( // (R05)
      @(posedge CLOCK) disable iff (RST)
      CMD_VALID && is_array && blocked && st_q == flash_regs_pkg::ST_IDLE
      |=> !wel_q && !ARRAY_START)
      else $error("protected target not refused");

   // protect level and its use
   chk_prot_stable: assert property ( // (R07)
      @(posedge CLOCK) disable iff (RST)
      !$past(write_status_cmd_go) |-> $stable(prot_q))
      else $error("protect level changed without status write");
   chk_write_status_cmd_no_wel: assert property ( // (R07)
      @(posedge CLOCK) disable iff (RST)
      CMD_VALID && CMD_OP == flash_regs_pkg::OP_WRITE_STATUS_CMD && !wel_q &&
      st_q == flash_regs_pkg::ST_IDLE |=> !busy_q)
      else $error("status write taken without latch");
   chk_start_pulse: assert property ( // (R08)
      @(posedge CLOCK) disable iff (RST) ARRAY_START |=> !ARRAY_START)
      else $error("launch pulse longer than one cycle");
   chk_chip_guard: assert property ( // (R09)
      @(posedge CLOCK) disable iff (RST)
      ARRAY_START && ARRAY_OP == flash_regs_pkg::OP_CHIP
      |-> $past(prot_q) == 4'h0)
      else $error("chip erase with protection set");
   chk_chip_refuse: assert property ( // (R09)
      @(posedge CLOCK) disable iff (RST)
      CMD_VALID && CMD_OP == flash_regs_pkg::OP_CHIP && prot_q != 4'h0
      |=> !ARRAY_START)
      else $error("chip erase not refused");
   chk_prot_reset: assert property ( // (R10)
      @(posedge CLOCK) disable iff (RST)
      $past(RST) |-> prot_q == `PROT_RESET)
      else $error("protect level not cleared by reset");

   // configuration fields change only through the status write
   chk_bottom_stable: assert property ( // (R12)
      @(posedge CLOCK) disable iff (RST)
      !$past(write_status_cmd_go) |-> $stable(bottom_q))
      else $error("bottom select changed without status write");
   chk_pre_stable: assert property ( // (R14)
      @(posedge CLOCK) disable iff (RST)
      !$past(write_status_cmd_go) |-> $stable(pre_q))
      else $error("preamble enable changed without status write");
   chk_drv_stable: assert property ( // (R15)
      @(posedge CLOCK) disable iff (RST)
      !$past(write_status_cmd_go) |-> $stable(drv_q))
      else $error("drive strength changed without status write");
   chk_cfg_apply: assert property ( // (R16)
      @(posedge CLOCK) disable iff (RST)
      write_status_cmd_go |=> ##1 CONFIG[4:0] == $past(CMD_CONFIG_DATA[4:0], 2))
      else $error("config not applied");
   // the pad flops reset to the same values as pre_q, drv_q and bottom_q, yet
   // the first edge after release is skipped
   chk_apply_pads: assert property ( // (R16)
      @(posedge CLOCK) disable iff (RST)
      !$past(RST) |-> PREAMBLE_ON == $past(pre_q) &&
      DRIVE_LEVEL == $past(drv_q) && PROTECT_BOTTOM == $past(bottom_q))
      else $error("pad settings do not follow config");

   // read-back views
   chk_status_view: assert property ( // (R17)
      @(posedge CLOCK) disable iff (RST)
      !$past(RST) |-> STATUS[5:0] == {$past(prot_q), $past(wel_q),
      $past(busy_q)})
      else $error("status read-back wrong");
   chk_cfg_view: assert property ( // (R17)
      @(posedge CLOCK) disable iff (RST)
      !$past(RST) |-> CONFIG[4:0] == {$past(pre_q), $past(bottom_q),
      $past(drv_q)})
      else $error("config read-back wrong");
   chk_reserved_zero: assert property ( // (R17)
      @(posedge CLOCK) disable iff (RST)
      STATUS[7:6] == 2'h0 && CONFIG[7:5] == 3'h0)
      else $error("reserved bits nonzero");
endmodule

// ### flash_host_model.sv
// Purpose: host controller model issuing decoded flash commands
// Assumes: device takes a command on the rising edge with valid high
// Notes: released address and data lines show inverted values, never a stale command
`timescale 1ns/10ps
module flash_host_model #(
   parameter int AW = 8
) (
   // clock
   input wire logic CLOCK,
   // command lines toward the device
   output logic CMD_VALID,
   output flash_regs_pkg::op_e CMD_OP,
   output logic [AW-1:0] CMD_ADDR,
   output logic [7:0] CMD_STATUS_DATA,
   output logic [7:0] CMD_CONFIG_DATA,
   // status read-back
   input wire logic [7:0] STATUS
);
   // idle lines at time zero
   initial begin
      CMD_VALID = 1'h0;
      CMD_OP = flash_regs_pkg::OP_NONE;
      CMD_ADDR = '0;
      CMD_STATUS_DATA = 8'h00;
      CMD_CONFIG_DATA = 8'h00;
   end

   // one-cycle command pulse, launched off the falling edge
   task automatic send(input flash_regs_pkg::op_e op,
                       input logic [AW-1:0] a,
                       input logic [7:0] sd, input logic [7:0] cd);
      @(negedge CLOCK);
      CMD_VALID = 1'h1;
      CMD_OP = op;
      CMD_ADDR = a;
      CMD_STATUS_DATA = sd;
      CMD_CONFIG_DATA = cd;
      @(negedge CLOCK);
      CMD_VALID = 1'h0;
      CMD_OP = flash_regs_pkg::OP_NONE;
      // inverted so a design reading idle lines cannot match by luck
      CMD_ADDR = ~a;
      CMD_STATUS_DATA = ~sd;
      CMD_CONFIG_DATA = ~cd;
   endtask

   task automatic poll_ready(output logic seen, output logic ok);
      int n;
      seen = 1'h0;
      n = 0;
      repeat (3) begin
         @(negedge CLOCK);
         seen = seen | (STATUS[0] === 1'h1);
      end
      while (STATUS[0] !== 1'h0 && n < 400) begin
         @(negedge CLOCK);
         n++;
      end
      ok = (n < 400);
   endtask
endmodule

// ### flash_status_config_regs_tb.sv
// Purpose: self-checking bench of the flash register block
// Assumes: AW of 8, so level 1 guards one unit at an end
// Notes: every latch check except the reset check and the one right after a write enable follows a completed busy poll
`timescale 1ns/10ps
module flash_status_config_regs_tb;
   logic CLOCK, RST, CMD_VALID, ARRAY_START;
   logic PREAMBLE_ON, PROTECT_BOTTOM;
   flash_regs_pkg::op_e CMD_OP, ARRAY_OP;
   logic [7:0] CMD_ADDR, CMD_STATUS_DATA, CMD_CONFIG_DATA, STATUS, CONFIG;
   logic [2:0] DRIVE_LEVEL;
   int n_fail = 0;
   int n_checks = 0;

   flash_status_config_regs #(.AW(8)) dut_u (.CLOCK(CLOCK), .RST(RST),
      .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR),
      .CMD_STATUS_DATA(CMD_STATUS_DATA), .CMD_CONFIG_DATA(CMD_CONFIG_DATA),
      .STATUS(STATUS), .CONFIG(CONFIG), .ARRAY_START(ARRAY_START),
      .ARRAY_OP(ARRAY_OP), .PREAMBLE_ON(PREAMBLE_ON),
      .DRIVE_LEVEL(DRIVE_LEVEL), .PROTECT_BOTTOM(PROTECT_BOTTOM));
   flash_host_model #(.AW(8)) host_u (.CLOCK(CLOCK), .CMD_VALID(CMD_VALID),
      .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR), .CMD_STATUS_DATA(CMD_STATUS_DATA),
      .CMD_CONFIG_DATA(CMD_CONFIG_DATA), .STATUS(STATUS));

   // 40 MHz clock
   initial begin
      CLOCK = 1'h0;
      forever #12.5 CLOCK = ~CLOCK;
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // a hang ends the run through the report
   task automatic wait_ready(output logic seen);
      logic ok;
      host_u.poll_ready(seen, ok);
      if (!ok) begin
         n_fail++;
         final_report();
      end
      @(negedge CLOCK);
   endtask

   // launch one array command, after a write enable when wen is set, expect go or refusal
   task automatic try_op(input flash_regs_pkg::op_e op, input logic [7:0] a,
                         input logic go, input logic wen);
      logic st, seen;
      st = 1'h0;
      if (wen) begin
         host_u.send(flash_regs_pkg::OP_WRITE_ENABLE_CMD, 8'h00, 8'h00, 8'h00);
         @(negedge CLOCK);
         check({7'h00, STATUS[1]}, 8'h01);
      end
      host_u.send(op, a, 8'h00, 8'h00);
      repeat (4) begin
         if (ARRAY_START === 1'h1) begin
            st = 1'h1;
            check({5'h00, ARRAY_OP}, {5'h00, op});
         end
         @(negedge CLOCK);
      end
      wait_ready(seen);
      check({6'h00, st, seen}, {6'h00, go, go});
      check(STATUS & 8'hC3, 8'h00);
   endtask

   // status write, then read-back of registers and applied settings
   task automatic write_status_cmd(input logic [7:0] sd, input logic [7:0] cd);
      logic seen;
      host_u.send(flash_regs_pkg::OP_WRITE_ENABLE_CMD, 8'h00, 8'h00, 8'h00);
      host_u.send(flash_regs_pkg::OP_WRITE_STATUS_CMD, 8'h00, sd, cd);
      wait_ready(seen);
      check({7'h00, seen}, 8'h01);
      check(STATUS, sd & 8'h3C);
      check(CONFIG, cd & 8'h1F);
      check({3'h0, PREAMBLE_ON, PROTECT_BOTTOM, DRIVE_LEVEL}, cd & 8'h1F);
   endtask

   task automatic s_reset();
      check(STATUS, 8'h00);
      check(CONFIG, 8'h07);
      check({5'h00, DRIVE_LEVEL}, 8'h07);
      check({6'h00, PREAMBLE_ON, PROTECT_BOTTOM}, 8'h00);
   endtask

   task automatic s_ops();
      try_op(flash_regs_pkg::OP_PROG, 8'h10, 1'h0, 1'h0);
      try_op(flash_regs_pkg::OP_PROG, 8'h10, 1'h1, 1'h1);
      try_op(flash_regs_pkg::OP_SECT, 8'hFF, 1'h1, 1'h1);
      try_op(flash_regs_pkg::OP_BLOCK, 8'h00, 1'h1, 1'h1);
      try_op(flash_regs_pkg::OP_CHIP, 8'h00, 1'h1, 1'h1);
   endtask

   // every drive code, both selects, reserved bits written as ones
   task automatic s_cfg();
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         write_status_cmd({3'h6, c, 2'h3}, {3'h7, c[0], c[1], c});
      end
   endtask

   task automatic s_protect();
      write_status_cmd(8'h04, 8'h07);
      try_op(flash_regs_pkg::OP_PROG, 8'hFF, 1'h0, 1'h1);
      try_op(flash_regs_pkg::OP_PROG, 8'h00, 1'h1, 1'h1);
      try_op(flash_regs_pkg::OP_CHIP, 8'h00, 1'h0, 1'h1);
      write_status_cmd(8'h04, 8'h0F);
      try_op(flash_regs_pkg::OP_SECT, 8'h00, 1'h0, 1'h1);
      try_op(flash_regs_pkg::OP_SECT, 8'hFF, 1'h1, 1'h1);
   endtask

   initial begin
      RST = 1'h1;
      repeat (16) @(negedge CLOCK);
      RST = 1'h0;
      repeat (2) @(negedge CLOCK);
      s_reset();
      s_ops();
      s_cfg();
      s_protect();
      final_report();
   end
endmodule
